// file: srcs_pkg.sv
package srcs_pkg;

  // ---------------------------------------------------------------
  // Counter and sequence timing, in internal RC clock cycles
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W          = 12;
  localparam int unsigned POR_DELAY      = 4096;
  localparam int unsigned PIN_DRIVE      = 32;
  localparam int unsigned INTERNAL_RESET_SIGNAL_EXTRA     = 32;
  localparam int unsigned STOP_LONG      = 4096;
  localparam int unsigned STOP_SHORT     = 32;
  localparam int unsigned PIN_MIN_NORMAL = 67;
  localparam int unsigned PIN_MIN_POR    = 4163;
  localparam int unsigned DOG_W          = 8;
  localparam int unsigned SVC_CLR_LSB    = 5;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_CAUSE     = 16'hfe01;
  localparam logic [15:0] ADDR_CFG1      = 16'h001f;
  localparam logic [15:0] ADDR_DOG_SVC   = 16'hffff;
  localparam logic [15:0] VEC_USER       = 16'hfffe;
  localparam logic [15:0] VEC_MONITOR    = 16'hfefe;
  localparam logic [7:0]  CAUSE_POR_RST  = 8'h80;
  localparam logic [7:0]  CFG1_RST       = 8'h00;
  localparam int unsigned CFG1_SHORT_STOP_RECOVERY_BIT_BIT = 7;
  localparam int unsigned CFG1_STOPE_BIT = 0;

  // Reset cause bit positions
  localparam int unsigned C_POR  = 7;
  localparam int unsigned C_PIN  = 6;
  localparam int unsigned C_DOG  = 5;
  localparam int unsigned C_ILLEGAL_OPCODE_CAUSE_FLAG = 4;
  localparam int unsigned C_ILLEGAL_ADDRESS_CAUSE_FLAG = 3;
  localparam int unsigned C_MOD  = 2;
  localparam int unsigned C_LVI  = 1;

  // Bus clock source selection
  typedef enum logic [1:0] {
    SRCS_OSC_DIV4 = 2'b00,
    SRCS_OSC_DIV2 = 2'b01,
    SRCS_PLL_DIV4 = 2'b10
  } srcs_clksel_type;

  // Sequencer states
  typedef enum logic [2:0] {
    SRCS_RUN     = 3'b000,
    SRCS_LONG    = 3'b001,
    SRCS_DRIVE   = 3'b010,
    SRCS_HOLD    = 3'b011,
    SRCS_STOP    = 3'b100,
    SRCS_PINWAIT = 3'b101
  } srcs_state_type;

  // Reset requests from the surrounding chip
  typedef struct packed {
    logic low_voltage_detector;
    logic dog_ovf;
    logic illegal_op;
    logic stop_instr;
    logic unmapped_fetch;
    logic mod_entry;
  } srcs_req_type;

endpackage

// file: srcs_sequencer.sv
`timescale 1ns/1ps
// Operation
// - User-mode bus clock is oscillator/4, oscillator/2 or PLL/4.
// - After power-on or low-voltage reset, bus clocks wait 4096 RC cycles; here clock enables stay off POR_CYC+64 ticks.
// - Stop exit counts RC cycles, 4096 or 32, before clocks restart.
// - Wait mode stops CPU clocks, peripheral clocks keep running.
// - Every reset asserts internal reset and selects user or monitor vector.
// - Internal reset returns all registers and modules to defaults; here it resets only cfg1, watchdog and stabilisation counters, cause flags are kept.
// - Internal resets clear the stabilisation counter; pin reset does not.
// - Each reset source sets its own cause flag.
// - Pin flag needs 67 low cycles, 4163 after power-on/low-voltage.
// - Internal reset drives pin low 32 cycles, internal reset 32 more.
// - Power-on/low-voltage hold pin low 4096+32, release 32 later.
// - Power-on sets power-on flag and clears all other flags.
// - Watchdog overflow resets and sets its flag; input is asynchronous.
// - Write to service address clears watchdog and counter bits 11..5.
// - Counter overflow clocks the watchdog counter.
// - Watchdog disabled only combinationally by test voltage conditions.
// - Illegal instruction or disabled stop instruction is illegal opcode reset.
// - Unmapped opcode fetch resets; unmapped data access does not.
// - Low-voltage detector sets its flag and runs the long sequence.
// - Monitor entry with erased vectors causes an internal reset.
// - Counter is 12 bits, counts each RC tick, free-running after reset.
// - Stop clears counter; short recovery bit shortens delay to 32.
// - Bus clock is clock generator output divided by two.
module srcs_sequencer #(
  parameter int unsigned POR_CYC = srcs_pkg::POR_DELAY
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic                   internal_rc_clock_i,
  input  wire logic                   oscillator_buffered_clock_i,
  input  wire logic                   pll_output_clock_i,
  input  wire srcs_pkg::srcs_clksel_type clk_sel_i,
  input  wire logic                   power_on_reset_signal_i,
  input  wire srcs_pkg::srcs_req_type req_i,
  input  wire logic                   ext_reset_pin_i,
  input  wire logic                   high_test_voltage_rst_i,
  input  wire logic                   high_test_voltage_irq_i,
  input  wire logic                   monitor_mode_i,
  input  wire logic                   break_state_i,
  input  wire logic                   stop_exit_i,
  input  wire logic                   wait_mode_i,
  input  wire logic [15:0]            addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic [7:0]                  rdata_o,
  output logic                        ext_reset_pin_o,
  output logic                        ext_reset_pin_oe_n_o,
  output logic                        internal_reset_signal_o,
  output logic [15:0]                 reset_vector_o,
  output logic                        cpu_clk_en_o,
  output logic                        periph_clk_en_o,
  output logic                        bus_clk_o,
  output logic                        watchdog_tick_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Every pin-side input passes two flops before use
  localparam int unsigned NS = 8;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  wire  [NS-1:0] raw_in = {internal_rc_clock_i, ext_reset_pin_i, high_test_voltage_rst_i,
                           high_test_voltage_irq_i, power_on_reset_signal_i, req_i.low_voltage_detector,
                           req_i.dog_ovf, req_i.mod_entry};
  always_ff @(posedge mclk_i) begin
    sync1 <= raw_in;
    sync2 <= sync1;
  end

  wire rc_s      = sync2[7];
  wire pin_low   = ~sync2[6];
  wire vtst_rst  = sync2[5];
  wire vtst_irq  = sync2[4];
  wire por_s     = sync2[3];
  wire lvi_s     = sync2[2];
  wire dog_s     = sync2[1];
  wire mod_s     = sync2[0];

  // Falling edge of the RC clock is the counter tick
  logic rc_d;
  wire  rc_tick = rc_d & ~rc_s;

  // ---------------------------------------------------------------
  // Bus clock divider
  // ---------------------------------------------------------------
  // Source clocks are sampled; real silicon would use a glitch-free mux
  logic osc_d;
  logic pll_d;
  logic [1:0] div_cnt;
  always_ff @(posedge mclk_i) begin
    osc_d <= oscillator_buffered_clock_i;
    pll_d <= pll_output_clock_i;
  end
  wire src_clk = (clk_sel_i == srcs_pkg::SRCS_PLL_DIV4) ? pll_d : osc_d;
  logic src_d;
  wire  src_rise = src_clk & ~src_d;
  // Toggle every source rise for /2, every second rise for /4
  wire  div_wrap = (clk_sel_i == srcs_pkg::SRCS_OSC_DIV2) ? 1'b1 : div_cnt[0];
  wire [1:0] next_div = div_wrap ? 2'h0 : div_cnt + 2'h1;
  wire  bus_toggle = src_rise & (div_cnt == 2'h0);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire hit_cause = addr_i == srcs_pkg::ADDR_CAUSE;
  wire hit_cfg1  = addr_i == srcs_pkg::ADDR_CFG1;
  wire svc_wr    = wr_i & (addr_i == srcs_pkg::ADDR_DOG_SVC);
  logic [7:0] cause;
  logic [7:0] cfg1;
  wire short_stop_recovery_bit     = cfg1[srcs_pkg::CFG1_SHORT_STOP_RECOVERY_BIT_BIT];
  wire stop_en   = cfg1[srcs_pkg::CFG1_STOPE_BIT];
  wire [7:0] next_rdata = ~rd_i ? 8'h00 : hit_cause ? cause : hit_cfg1 ? cfg1 : 8'h00;

  // ---------------------------------------------------------------
  // Reset source decode
  // ---------------------------------------------------------------
  // Disable is purely combinational so noise cannot latch it off
  wire dog_disable = (monitor_mode_i & (vtst_rst | vtst_irq))
                   | (break_state_i & vtst_rst);
  wire dog_req  = dog_s & ~dog_disable;
  wire illegal_opcode_cause_flag_req = req_i.illegal_op | (req_i.stop_instr & ~stop_en);
  wire illegal_address_cause_flag_req = req_i.unmapped_fetch;
  wire long_req = por_s | lvi_s;
  wire short_req = dog_req | illegal_opcode_cause_flag_req | illegal_address_cause_flag_req | mod_s;

  // ---------------------------------------------------------------
  // Sequencer state and counters
  // ---------------------------------------------------------------
  srcs_pkg::srcs_state_type state;
  srcs_pkg::srcs_state_type next_state;
  logic [srcs_pkg::CNT_W-1:0] cnt;
  logic [12:0] seq_cnt;
  logic [12:0] pin_cnt;
  logic        long_seq;
  logic [srcs_pkg::DOG_W-1:0] dog_cnt;

  localparam logic [12:0] LONG_END  = 13'(POR_CYC + srcs_pkg::PIN_DRIVE - 1);
  localparam logic [12:0] DRIVE_END = 13'(srcs_pkg::PIN_DRIVE - 1);
  localparam logic [12:0] HOLD_END  = 13'(srcs_pkg::INTERNAL_RESET_SIGNAL_EXTRA - 1);
  localparam logic [12:0] STOP_LEND = 13'(srcs_pkg::STOP_LONG - 1);
  localparam logic [12:0] STOP_SEND = 13'(srcs_pkg::STOP_SHORT - 1);
  localparam logic [12:0] PIN_NORM  = 13'(srcs_pkg::PIN_MIN_NORMAL);
  localparam logic [12:0] PIN_LONG  = 13'(srcs_pkg::PIN_MIN_POR);

  wire [12:0] stop_lim = short_stop_recovery_bit ? STOP_SEND : STOP_LEND;
  wire seq_done = rc_tick & (seq_cnt == ((state == srcs_pkg::SRCS_LONG) ? LONG_END :
                  (state == srcs_pkg::SRCS_DRIVE) ? DRIVE_END :
                  (state == srcs_pkg::SRCS_HOLD) ? HOLD_END : stop_lim));
  wire [12:0] pin_need = long_seq ? PIN_LONG : PIN_NORM;
  wire pin_qual = pin_low & (pin_cnt >= pin_need - 13'h1) & rc_tick;
  wire cnt_ovf  = rc_tick & (&cnt);

  // Next-state logic; any internal source preempts the current sequence, except short sources during the long sequence
  always_comb begin
    next_state = state;
    unique case (state)
      srcs_pkg::SRCS_RUN: begin
        if (pin_low)
          next_state = srcs_pkg::SRCS_PINWAIT;
        else if (req_i.stop_instr & stop_en)
          next_state = srcs_pkg::SRCS_STOP;
      end
      srcs_pkg::SRCS_LONG:    if (seq_done) next_state = srcs_pkg::SRCS_HOLD;
      srcs_pkg::SRCS_DRIVE:   if (seq_done) next_state = srcs_pkg::SRCS_HOLD;
      srcs_pkg::SRCS_HOLD:    if (seq_done) next_state = srcs_pkg::SRCS_RUN;
      srcs_pkg::SRCS_STOP:    if (stop_exit_i & seq_done) next_state = srcs_pkg::SRCS_RUN;
      srcs_pkg::SRCS_PINWAIT: if (!pin_low) next_state = srcs_pkg::SRCS_HOLD;
      default:                next_state = srcs_pkg::SRCS_RUN;
    endcase
    if (long_req)
      next_state = srcs_pkg::SRCS_LONG;
    else if (short_req && state != srcs_pkg::SRCS_LONG)
      next_state = srcs_pkg::SRCS_DRIVE;
  end

  // ---------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------
  // Sequence and pin counters advance on RC ticks only
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state    <= srcs_pkg::SRCS_LONG;
      seq_cnt  <= 13'h0;
      pin_cnt  <= 13'h0;
      long_seq <= 1'b1;
      rc_d     <= 1'b0;
    end else begin
      rc_d  <= rc_s;
      state <= next_state;
      if (next_state != state)
        seq_cnt <= 13'h0;
      else if (rc_tick)
        seq_cnt <= seq_cnt + 13'h1;
      if (!pin_low)
        pin_cnt <= 13'h0;
      else if (rc_tick && pin_cnt != 13'h1fff)
        pin_cnt <= pin_cnt + 13'h1;
      if (long_req)
        long_seq <= 1'b1;
      else if (state == srcs_pkg::SRCS_RUN)
        long_seq <= 1'b0;
    end
  end

  // Stabilisation counter: cleared by internal resets and stop, not by the pin
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (long_req | short_req | (req_i.stop_instr & stop_en)) begin
      cnt <= '0;
    end else if (svc_wr) begin
      cnt <= {7'h0, cnt[srcs_pkg::SVC_CLR_LSB-1:0]};
    end else if (rc_tick) begin
      cnt <= cnt + 12'h1;
    end
  end

  // Watchdog prescaled counter, cleared by the service write
  always_ff @(posedge mclk_i) begin
    if (rst_i || svc_wr || state != srcs_pkg::SRCS_RUN)
      dog_cnt <= '0;
    else if (cnt_ovf)
      dog_cnt <= dog_cnt + 8'h1;
  end

  // Cause flags; power-on alone clears the others
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cause <= srcs_pkg::CAUSE_POR_RST;
    end else if (por_s) begin
      cause <= srcs_pkg::CAUSE_POR_RST;
    end else begin
      if (lvi_s)    cause[srcs_pkg::C_LVI]  <= 1'b1;
      if (dog_req)  cause[srcs_pkg::C_DOG]  <= 1'b1;
      if (illegal_opcode_cause_flag_req) cause[srcs_pkg::C_ILLEGAL_OPCODE_CAUSE_FLAG] <= 1'b1;
      if (illegal_address_cause_flag_req) cause[srcs_pkg::C_ILLEGAL_ADDRESS_CAUSE_FLAG] <= 1'b1;
      if (mod_s)    cause[srcs_pkg::C_MOD]  <= 1'b1;
      if (pin_qual) cause[srcs_pkg::C_PIN]  <= 1'b1;
    end
  end

  // Configuration register and registered outputs
  wire in_reset = (state == srcs_pkg::SRCS_LONG) | (state == srcs_pkg::SRCS_DRIVE)
                | (state == srcs_pkg::SRCS_HOLD) | (state == srcs_pkg::SRCS_PINWAIT);
  wire drive_pin = (state == srcs_pkg::SRCS_LONG) | (state == srcs_pkg::SRCS_DRIVE);
  // Clocks stay off for the whole reset tail so no instruction runs inside reset
  wire clocks_on = (state == srcs_pkg::SRCS_RUN);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg1                    <= srcs_pkg::CFG1_RST;
      rdata_o                 <= 8'h00;
      ext_reset_pin_o         <= 1'b0;
      ext_reset_pin_oe_n_o    <= 1'b0;
      internal_reset_signal_o <= 1'b1;
      reset_vector_o          <= srcs_pkg::VEC_USER;
      cpu_clk_en_o            <= 1'b0;
      periph_clk_en_o         <= 1'b0;
      bus_clk_o               <= 1'b0;
      watchdog_tick_o         <= 1'b0;
      div_cnt                 <= 2'h0;
      src_d                   <= 1'b0;
    end else begin
      if (in_reset)
        cfg1 <= srcs_pkg::CFG1_RST;
      else if (wr_i & hit_cfg1)
        cfg1 <= wdata_i;
      rdata_o                 <= next_rdata;
      ext_reset_pin_o         <= 1'b0;
      ext_reset_pin_oe_n_o    <= ~drive_pin;
      internal_reset_signal_o <= in_reset;
      reset_vector_o          <= monitor_mode_i ? srcs_pkg::VEC_MONITOR : srcs_pkg::VEC_USER;
      cpu_clk_en_o            <= clocks_on & ~wait_mode_i;
      periph_clk_en_o         <= clocks_on;
      src_d                   <= src_clk;
      if (src_rise)
        div_cnt <= next_div;
      if (bus_toggle)
        bus_clk_o <= ~bus_clk_o;
      watchdog_tick_o         <= cnt_ovf;
    end
  end

endmodule

// file: srcs_sequencer_asserts.sv
`timescale 1ns/1ps
module srcs_sequencer_asserts (
  input wire logic                      mclk_i,
  input wire logic                      rst_i,
  input wire srcs_pkg::srcs_req_type    req_i,
  input wire logic                      monitor_mode_i,
  input wire logic                      wait_mode_i,
  input wire logic                      rd_i,
  input wire logic [7:0]                rdata_o,
  input wire logic                      ext_reset_pin_o,
  input wire logic                      ext_reset_pin_oe_n_o,
  input wire logic                      internal_reset_signal_o,
  input wire logic [15:0]               reset_vector_o,
  input wire logic                      cpu_clk_en_o,
  input wire logic                      watchdog_tick_o
);
  // ---------------------------------------------------------------
  // Port relations, one clock domain
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Read data stands only in the cycle after a read strobe
  property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  // Vector follows the mode once the mode has settled
  property p_vec;
    $stable(monitor_mode_i) |->
      reset_vector_o == (monitor_mode_i ? srcs_pkg::VEC_MONITOR : srcs_pkg::VEC_USER);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong reset vector");
  property p_pin_val; ext_reset_pin_o == 1'b0; endproperty
  a_pin_val: assert property (p_pin_val) else $error("pin drives high");
  // Pin is only pulled while the chip is itself in reset
  property p_drive_internal_reset_signal;
    !ext_reset_pin_oe_n_o && !$past(ext_reset_pin_oe_n_o) |-> internal_reset_signal_o;
  endproperty
  a_drive_internal_reset_signal: assert property (p_drive_internal_reset_signal) else $error("pin driven outside reset");
  // Internal reset outlives the pin drive; 32 ticks exceed 8 clocks
  property p_internal_reset_signal_tail;
    $rose(ext_reset_pin_oe_n_o) && internal_reset_signal_o |-> internal_reset_signal_o [*8];
  endproperty
  a_internal_reset_signal_tail: assert property (p_internal_reset_signal_tail) else $error("internal reset tail short");
  property p_internal_reset_signal_clk;
    internal_reset_signal_o && $past(internal_reset_signal_o) |-> !cpu_clk_en_o;
  endproperty
  a_internal_reset_signal_clk: assert property (p_internal_reset_signal_clk) else $error("cpu clock runs in reset");
  property p_wait; wait_mode_i && $past(wait_mode_i) |-> !cpu_clk_en_o; endproperty
  a_wait: assert property (p_wait) else $error("cpu clock runs in wait");
  property p_tick; watchdog_tick_o |=> !watchdog_tick_o; endproperty
  a_tick: assert property (p_tick) else $error("watchdog tick too long");
  // Request to pin drive allows sync flops plus one RC tick
  property p_illegal_opcode_cause_flag;
    (req_i.illegal_op || req_i.stop_instr) && !internal_reset_signal_o
      |-> ##[1:20] !ext_reset_pin_oe_n_o;
  endproperty
  a_illegal_opcode_cause_flag: assert property (p_illegal_opcode_cause_flag) else $error("no reset on illegal opcode");
  property p_fetch;
    req_i.unmapped_fetch && !internal_reset_signal_o |-> ##[1:20] !ext_reset_pin_oe_n_o;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no reset on bad fetch");
  property p_dog;
    $rose(req_i.dog_ovf) && !internal_reset_signal_o |-> ##[2:20] !ext_reset_pin_oe_n_o;
  endproperty
  a_dog: assert property (p_dog) else $error("no reset on watchdog");
endmodule

bind srcs_sequencer srcs_sequencer_asserts i_srcs_sequencer_asserts (.mclk_i, .rst_i,
  .req_i, .monitor_mode_i, .wait_mode_i, .rd_i, .rdata_o, .ext_reset_pin_o,
  .ext_reset_pin_oe_n_o, .internal_reset_signal_o, .reset_vector_o, .cpu_clk_en_o,
  .watchdog_tick_o);

// file: srcs_far_model.sv
`timescale 1ns/1ps
module srcs_far_model (
  input  wire logic mclk_i,
  input  wire logic pull_low_i,
  input  wire logic pin_drive_n_i,
  input  wire logic pin_val_i,
  output logic      rc_clk_o,
  output logic      osc_clk_o,
  output logic      pll_clk_o,
  output wire logic pin_level_o
);
  logic [1:0] div = 2'h0;
  // RC runs free at a sixth of the system rate, slow enough for two sync flops
  always @(posedge mclk_i) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    if (div == 2'h2) rc_clk_o <= ~rc_clk_o;
    osc_clk_o <= ~osc_clk_o;
    pll_clk_o <= osc_clk_o;
  end
  initial begin
    rc_clk_o  = 1'b0;
    osc_clk_o = 1'b0;
    pll_clk_o = 1'b0;
  end
  // Pull-up wins when neither the chip nor the outside world pulls low
  assign pin_level_o = !pin_drive_n_i ? pin_val_i : !pull_low_i;
endmodule

// file: srcs_sequencer_test.sv
`timescale 1ns/1ps
module srcs_sequencer_test;
  localparam int unsigned POR_T = 16;
  localparam logic [5:0] SRC_REQ [6] = '{6'h08, 6'h04, 6'h02, 6'h10, 6'h01, 6'h20};
  localparam int SRC_BIT [6] = '{4, 4, 3, 5, 2, 1};
  logic mclk_i, rst_i, wait_mode_i, monitor_mode_i, rd_i, wr_i, pull_low;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, d;
  srcs_pkg::srcs_req_type req_i;
  wire rc, osc, pll, pin, ext_reset_pin_o, ext_reset_pin_oe_n_o, internal_reset_signal_o;
  wire cpu_clk_en_o, periph_clk_en_o, bus_clk_o, watchdog_tick_o;
  wire [7:0] rdata_o;
  wire [15:0] reset_vector_o;
  int fail_count = 0, cmp_count = 0, ticks = 0, t0, t1;

  srcs_sequencer #(.POR_CYC(POR_T)) i_srcs_sequencer (.mclk_i, .rst_i,
    .internal_rc_clock_i(rc), .oscillator_buffered_clock_i(osc), .pll_output_clock_i(pll),
    .clk_sel_i(srcs_pkg::SRCS_OSC_DIV4), .power_on_reset_signal_i(rst_i), .req_i,
    .ext_reset_pin_i(pin), .high_test_voltage_rst_i(1'b0), .high_test_voltage_irq_i(1'b0),
    .monitor_mode_i, .break_state_i(1'b0), .stop_exit_i(1'b0), .wait_mode_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .ext_reset_pin_o, .ext_reset_pin_oe_n_o,
    .internal_reset_signal_o, .reset_vector_o, .cpu_clk_en_o, .periph_clk_en_o,
    .bus_clk_o, .watchdog_tick_o);
  srcs_far_model i_srcs_far_model (.mclk_i, .pull_low_i(pull_low),
    .pin_drive_n_i(ext_reset_pin_oe_n_o), .pin_val_i(ext_reset_pin_o), .rc_clk_o(rc),
    .osc_clk_o(osc), .pll_clk_o(pll), .pin_level_o(pin));

  // ---------------------------------------------------------------
  // Clock, tick counter and bus tasks
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(negedge rc) ticks <= ticks + 1;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Read data is taken in the one cycle that it stands
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Bounded wait on pin drive (w=0), internal reset (1) or watchdog tick (2)
  task automatic wait_sig(input int w, input logic lvl);
    logic s;
    for (int i = 0; i < 30000; i++) begin
      s = (w == 0) ? ext_reset_pin_oe_n_o : (w == 1) ? internal_reset_signal_o : watchdog_tick_o;
      if (s === lvl) return;
      @(posedge mclk_i);
    end
    chk("wait_level", 16'(lvl), 16'(~lvl));
  endtask
  task automatic wait_ticks(input int n);
    int t;
    t = ticks;
    while (ticks < t + n) @(posedge mclk_i);
  endtask
  // Pin drive length, then internal reset tail, in RC ticks
  task automatic seq(input int exp_pin);
    wait_sig(0, 1'b0);
    t0 = ticks;
    wait_sig(0, 1'b1);
    t1 = ticks;
    chk_rng("pin_ticks", exp_pin - 2, exp_pin + 2, t1 - t0);
    wait_sig(1, 1'b0);
    chk_rng("internal_reset_signal_ticks", 30, 34, ticks - t1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1; wait_mode_i = 1'b0; monitor_mode_i = 1'b0; rd_i = 1'b0; wr_i = 1'b0;
    pull_low = 1'b0; addr_i = 16'h0000; wdata_i = 8'h00; req_i = '0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    bus_rd(srcs_pkg::ADDR_CAUSE, d);
    chk("cause_por", 16'(srcs_pkg::CAUSE_POR_RST), 16'(d));
    seq(POR_T + 32);
    repeat (3) @(posedge mclk_i);
    chk("cpu_clk_en", 16'h0001, 16'(cpu_clk_en_o));
    $display("test power_on done");
    bus_wr(srcs_pkg::ADDR_CFG1, 8'h81);
    bus_rd(srcs_pkg::ADDR_CFG1, d);
    chk("cfg1", 16'h0081, 16'(d));
    bus_rd(16'h1234, d);
    chk("unmapped", 16'h0000, 16'(d));
    bus_wr(srcs_pkg::ADDR_CAUSE, 8'h00);
    bus_rd(srcs_pkg::ADDR_CAUSE, d);
    chk("cause_ro", 16'(srcs_pkg::CAUSE_POR_RST), 16'(d));
    $display("test registers done");
    // Stop request comes after a reset has cleared the stop enable
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_i);
      req_i <= srcs_pkg::srcs_req_type'(SRC_REQ[i]);
      repeat (4) @(posedge mclk_i);
      req_i <= '0;
      seq((i == 5) ? POR_T + 32 : 32);
      bus_rd(srcs_pkg::ADDR_CAUSE, d);
      chk("cause_bit", 16'h0001, 16'(d[SRC_BIT[i]]));
      bus_rd(srcs_pkg::ADDR_CFG1, d);
      chk("cfg1_reset", 16'(srcs_pkg::CFG1_RST), 16'(d));
    end
    $display("test sources done");
    t0 = ticks;
    wait_sig(2, 1'b1);
    chk_rng("first_tick", 3990, 4140, ticks - t0);
    wait_ticks(2048);
    bus_wr(srcs_pkg::ADDR_DOG_SVC, 8'h5a);
    t0 = ticks;
    wait_sig(2, 1'b1);
    chk_rng("svc_tick", 4060, 4100, ticks - t0);
    $display("test watchdog done");
    for (int n = 20; n <= 80; n += 60) begin
      @(posedge mclk_i);
      pull_low <= 1'b1;
      wait_ticks(n);
      pull_low <= 1'b0;
      wait_sig(1, 1'b0);
      bus_rd(srcs_pkg::ADDR_CAUSE, d);
      chk("cause_pin", 16'(n > 67), 16'(d[srcs_pkg::C_PIN]));
    end
    $display("test pin done");
    wait_mode_i <= 1'b1;
    monitor_mode_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("wait_cpu", 16'h0000, 16'(cpu_clk_en_o));
    chk("wait_periph", 16'h0001, 16'(periph_clk_en_o));
    chk("vec_mon", srcs_pkg::VEC_MONITOR, reset_vector_o);
    wait_mode_i <= 1'b0;
    monitor_mode_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("vec_user", srcs_pkg::VEC_USER, reset_vector_o);
    @(posedge bus_clk_o);
    t0 = int'($time);
    @(posedge bus_clk_o);
    chk_rng("bus_period", 800, 800, int'($time) - t0);
    $display("test modes done");
    tally_and_finish();
  end
  // Tests need about 70000 cycles
  initial begin
    repeat (95000) @(posedge mclk_i);
    fail_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule
